/* include/srwg_pkg.sv */
// shared constants and types for the supervisor reset and write guard
package srwg_pkg;

  // clock and time base
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned TICK_NS       = 1000;
  localparam int unsigned TICK_CYCLES   = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // reset hold durations, in time-base ticks of one microsecond
  localparam int unsigned HOLD0_US = 1000;
  localparam int unsigned HOLD1_US = 2000;
  localparam int unsigned HOLD2_US = 4000;
  localparam int unsigned HOLD3_US = 8000;
  localparam int unsigned HOLD_W   = 16;

  // register bus shape
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL   = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_MASK   = 4'h8;
  localparam logic [ADDR_W-1:0] OFF_STATE  = 4'hC;

  // control register fields
  localparam int unsigned CTRL_SEL_LO  = 0;
  localparam int unsigned CTRL_SEL_HI  = 1;
  localparam int unsigned CTRL_LOCK_LO = 2;
  localparam int unsigned CTRL_LOCK_HI = 3;
  localparam int unsigned CTRL_W       = 4;
  localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;

  // status and mask fields, one per event
  localparam int unsigned EV_RST_ON  = 0;
  localparam int unsigned EV_RST_OFF = 1;
  localparam int unsigned EV_FAIL2   = 2;
  localparam int unsigned EV_FAIL3   = 3;
  localparam int unsigned EV_WR_DENY = 4;
  localparam int unsigned EV_N       = 5;
  localparam logic [EV_N-1:0] STATUS_RST = 5'h00;
  localparam logic [EV_N-1:0] MASK_RST   = 5'h00;

  // state readout fields
  localparam int unsigned ST_BIT_RESET = 0;
  localparam int unsigned ST_BIT_FAIL2 = 1;
  localparam int unsigned ST_BIT_FAIL3 = 2;
  localparam int unsigned ST_BIT_WP    = 3;
  localparam int unsigned ST_BIT_FSM   = 4;

  typedef enum logic [2:0] {
    ST_CAUSE = 3'b001,
    ST_HOLD  = 3'b010,
    ST_RUN   = 3'b100
  } srwg_rst_state_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              we;
    logic              re;
  } srwg_bus_req_s;

  typedef struct packed {
    logic req;
    logic nonvol;
  } srwg_wr_req_s;

endpackage

/* core/srwg_hold_timer.sv */
// reset hold timer: microsecond time base and selectable down counter
`timescale 1ns/1ps

module srwg_hold_timer #(
  parameter int unsigned TICKS = srwg_pkg::TICK_CYCLES,
  parameter int unsigned HOLD0 = srwg_pkg::HOLD0_US,
  parameter int unsigned HOLD1 = srwg_pkg::HOLD1_US,
  parameter int unsigned HOLD2 = srwg_pkg::HOLD2_US,
  parameter int unsigned HOLD3 = srwg_pkg::HOLD3_US
) (
  // clock, reset, enable
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  // control
  input  wire logic       start,
  input  wire logic       clear,
  input  wire logic [1:0] sel,
  // result
  output logic            done
);
  import srwg_pkg::*;

  localparam int unsigned PRE_W = (TICKS > 1) ? $clog2(TICKS) : 1;

  if (TICKS < 1 || HOLD0 < 1 || HOLD1 < 1 || HOLD2 < 1 || HOLD3 < 1 ||
      HOLD0 >= 2**HOLD_W || HOLD1 >= 2**HOLD_W || HOLD2 >= 2**HOLD_W || HOLD3 >= 2**HOLD_W) begin : g_chk
    $error("hold timer parameters out of range");
  end

  logic [PRE_W-1:0]  pre_q;
  logic [HOLD_W-1:0] remain_q;
  logic              armed_q;
  logic [HOLD_W-1:0] loadVal;
  logic              tick;

  // four durations picked by the select bits [RULE13]
  assign loadVal = (sel == 2'd0) ? HOLD_W'(HOLD0) :
                   (sel == 2'd1) ? HOLD_W'(HOLD1) :
                   (sel == 2'd2) ? HOLD_W'(HOLD2) : HOLD_W'(HOLD3);
  assign tick    = (pre_q == PRE_W'(TICKS - 1));

  always_ff @(posedge clk) begin
    if (rst) begin
      pre_q    <= '0;
      remain_q <= '0;
      armed_q  <= 1'b0;
      done     <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      if (clear) begin
        armed_q <= 1'b0;
      end else if (start) begin
        armed_q  <= 1'b1;
        pre_q    <= '0;
        remain_q <= loadVal; // [RULE13]
      end else if (armed_q) begin
        pre_q <= tick ? '0 : pre_q + 1'b1;
        if (tick) begin
          remain_q <= remain_q - 1'b1;
          if (remain_q == HOLD_W'(1)) begin
            armed_q <= 1'b0;
            done    <= 1'b1;
          end
        end
      end
    end
  end

  a_done_after_arm: assert property (@(posedge clk) disable iff (rst)
    done |-> $past(armed_q)) // [RULE13]
    else $error("hold timer finished while not armed");

endmodule

/* core/srwg_supervisor.sv */
// supervisor: reset generation, monitor fail outputs, write guard, registers
//
// Added by the designer: the placing of the registers and strobed register access.
`timescale 1ns/1ps

//
// Contract
// [RULE1] third fail output is high while the third comparator reports above its threshold, low otherwise.
// [RULE2] third fail output follows its comparator with no timeout or delay stage.
// [RULE3] second fail output is high while the second comparator reports above its threshold, low otherwise.
// [RULE4] second fail output has no power-up timeout and tracks its comparator from power-up on.
// [RULE5] a high manual reset input starts a reset cycle and drives the reset output high.
// [RULE6] after manual reset falls, reset stays high for the whole configured hold time.
// [RULE7] two select bits of the control register pick the hold time for manual and power-up resets alike.
// [RULE8] reset output is high whenever the supply comparator reports the supply below its trip threshold.
// [RULE9] at power-up reset is held until the hold time has passed after the supply reads stable.
// [RULE10] while write protect is high every nonvolatile write is refused.
// [RULE11] while write protect is high and the lock bits are not zero every write is refused.
// [RULE12] an undriven write protect input counts as low, leaving protection off. The code has no pull-down of its own and relies on one on the board.
// [RULE13] the hold time is a counter on an internal time base with four selectable durations.
module srwg_supervisor #(
  parameter int unsigned HOLD0 = srwg_pkg::HOLD0_US,
  parameter int unsigned HOLD1 = srwg_pkg::HOLD1_US,
  parameter int unsigned HOLD2 = srwg_pkg::HOLD2_US,
  parameter int unsigned HOLD3 = srwg_pkg::HOLD3_US,
  parameter int unsigned TICKS = srwg_pkg::TICK_CYCLES
) (
  // clock, reset, enable
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     ce,
  // comparator and pin inputs
  input  wire logic                     supplyLowIn,
  input  wire logic                     manualResetIn,
  input  wire logic                     secondMonitorIn,
  input  wire logic                     thirdMonitorIn,
  input  wire logic                     writeProtectIn,
  // write requests from the serial side
  input  wire srwg_pkg::srwg_wr_req_s   wrReq,
  output logic                          wrGrant,
  output logic                          wrDeny,
  // register port
  input  wire srwg_pkg::srwg_bus_req_s  busReq,
  output logic [srwg_pkg::DATA_W-1:0]   rdData,
  // supervisor outputs
  output logic                          resetOut,
  output logic                          secondMonitorFailOut,
  output logic                          thirdMonitorFailOut,
  output logic                          irq
);
  import srwg_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // register decode

  function automatic logic regHit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    regHit = (a == off);
  endfunction

  logic wrCtrl;
  logic wrMask;
  logic rdStatus;
  logic rdCtrl;
  logic rdMask;
  logic rdState;

  assign wrCtrl   = busReq.we && regHit(busReq.addr, OFF_CTRL);
  assign wrMask   = busReq.we && regHit(busReq.addr, OFF_MASK);
  assign rdCtrl   = busReq.re && regHit(busReq.addr, OFF_CTRL);
  assign rdStatus = busReq.re && regHit(busReq.addr, OFF_STATUS);
  assign rdMask   = busReq.re && regHit(busReq.addr, OFF_MASK);
  assign rdState  = busReq.re && regHit(busReq.addr, OFF_STATE);

  ////////////////////////////////////////////////////////////////////////////
  // control, mask

  logic [CTRL_W-1:0] ctrl_q;
  logic [EV_N-1:0]   mask_q;
  logic [1:0]        timeoutSel;
  logic [1:0]        lockBits;

  // select bits steer both manual and power-up hold [RULE7]
  assign timeoutSel = {ctrl_q[CTRL_SEL_HI], ctrl_q[CTRL_SEL_LO]};
  assign lockBits   = {ctrl_q[CTRL_LOCK_HI], ctrl_q[CTRL_LOCK_LO]};

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q <= CTRL_RST;
      mask_q <= MASK_RST;
    end else if (ce) begin
      if (wrCtrl) ctrl_q <= busReq.wdata[CTRL_W-1:0];
      if (wrMask) mask_q <= busReq.wdata[EV_N-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset sequencer

  srwg_rst_state_e state_q;
  srwg_rst_state_e state_d;
  logic            cause;
  logic            timerStart;
  logic            timerDone;
  logic            resetOut_d;

  // supply low or manual reset both force reset [RULE5] [RULE8]
  assign cause = supplyLowIn | manualResetIn;

  always_comb begin
    state_d    = state_q;
    timerStart = 1'b0;
    unique case (state_q)
      ST_CAUSE: begin
        if (!cause) begin
          state_d    = ST_HOLD;
          timerStart = 1'b1; // [RULE6] [RULE9]
        end
      end
      ST_HOLD: begin
        if (cause) begin
          state_d = ST_CAUSE;
        end else if (timerDone) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (cause) begin
          state_d = ST_CAUSE;
        end
      end
      default: state_d = ST_CAUSE;
    endcase
  end

  // reset stays high through cause and hold [RULE5] [RULE6] [RULE8]
  assign resetOut_d = (state_d != ST_RUN);

  // power-up counts as a cause: sequence starts in ST_CAUSE [RULE9]
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q  <= ST_CAUSE;
      resetOut <= 1'b1;
    end else if (ce) begin
      state_q  <= state_d;
      resetOut <= resetOut_d;
    end
  end

  srwg_hold_timer #(
    .TICKS (TICKS),
    .HOLD0 (HOLD0),
    .HOLD1 (HOLD1),
    .HOLD2 (HOLD2),
    .HOLD3 (HOLD3)
  ) u_timer (
    .clk   (clk),
    .rst   (rst),
    .ce    (ce),
    .start (timerStart),
    .clear (cause),
    .sel   (timeoutSel),
    .done  (timerDone)
  );

  ////////////////////////////////////////////////////////////////////////////
  // monitor fail outputs

  // one flop only, no filter or hold: outputs must stay registered
  always_ff @(posedge clk) begin
    if (rst) begin
      secondMonitorFailOut <= 1'b0;
      thirdMonitorFailOut  <= 1'b0;
    end else if (ce) begin
      secondMonitorFailOut <= secondMonitorIn; // [RULE3] [RULE4]
      thirdMonitorFailOut  <= thirdMonitorIn;  // [RULE1] [RULE2]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write guard

  logic wpActive;
  logic wrRefuse;

  // pull-down lives on the board; a low or idle pin reads unprotected [RULE12]
  assign wpActive = writeProtectIn;
  assign wrRefuse = wpActive && (wrReq.nonvol || (lockBits != 2'b00)); // [RULE10] [RULE11]

  always_ff @(posedge clk) begin
    if (rst) begin
      wrGrant <= 1'b0;
      wrDeny  <= 1'b0;
    end else if (ce) begin
      wrGrant <= wrReq.req && !wrRefuse;
      wrDeny  <= wrReq.req && wrRefuse;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // events, status, interrupt

  logic [EV_N-1:0] event_w;
  logic [EV_N-1:0] status_q;
  logic [EV_N-1:0] status_d;

  assign event_w[EV_RST_ON]  = resetOut_d && !resetOut;
  assign event_w[EV_RST_OFF] = !resetOut_d && resetOut;
  assign event_w[EV_FAIL2]   = secondMonitorIn != secondMonitorFailOut;
  assign event_w[EV_FAIL3]   = thirdMonitorIn != thirdMonitorFailOut;
  assign event_w[EV_WR_DENY] = wrReq.req && wrRefuse;

  // a read clears, an event in the same cycle still lands
  for (genvar i = 0; i < EV_N; i++) begin : g_status
    assign status_d[i] = event_w[i] | (status_q[i] & ~rdStatus);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      status_q <= STATUS_RST;
      irq      <= 1'b0;
    end else if (ce) begin
      status_q <= status_d;
      irq      <= |(status_d & mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data, one cycle after the strobe

  logic [DATA_W-1:0] stateView;
  logic [DATA_W-1:0] rdData_d;

  assign stateView = DATA_W'({state_q, writeProtectIn, thirdMonitorFailOut,
                              secondMonitorFailOut, resetOut});

  assign rdData_d = rdCtrl   ? DATA_W'(ctrl_q)   :
                    rdStatus ? DATA_W'(status_q) :
                    rdMask   ? DATA_W'(mask_q)   :
                    rdState  ? stateView         : '0;

  always_ff @(posedge clk) begin
    if (rst) begin
      rdData <= '0;
    end else if (ce) begin
      rdData <= rdData_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_cause_drop;
    ce && !cause && $past(cause) && $past(ce);
  endsequence

  sequence s_held_two;
    resetOut [*2];
  endsequence

  property p_hold_after_drop;
    s_cause_drop |=> s_held_two;
  endproperty

  a_third_fail_follow: assert property ( // [RULE1] [RULE2]
    ce |=> thirdMonitorFailOut == $past(thirdMonitorIn))
    else $error("third fail output does not track its comparator");

  a_second_fail_follow: assert property ( // [RULE3] [RULE4]
    ce |=> secondMonitorFailOut == $past(secondMonitorIn))
    else $error("second fail output does not track its comparator");

  a_manual_reset_out: assert property ( // [RULE5]
    ce && manualResetIn |=> resetOut && state_q == ST_CAUSE)
    else $error("manual reset did not assert reset");

  a_supply_low_out: assert property ( // [RULE8]
    ce && supplyLowIn |=> resetOut)
    else $error("low supply did not assert reset");

  a_hold_after_drop: assert property (p_hold_after_drop) // [RULE6] [RULE9]
    else $error("reset released before hold time");

  a_release_on_done: assert property ( // [RULE7] [RULE13]
    $fell(resetOut) |-> $past(timerDone) && !$past(cause))
    else $error("reset released without timer expiry");

  a_nv_write_refused: assert property ( // [RULE10]
    ce && wrReq.req && wrReq.nonvol && writeProtectIn |=> wrDeny && !wrGrant)
    else $error("nonvolatile write passed while protected");

  a_lock_write_refused: assert property ( // [RULE11]
    ce && wrReq.req && writeProtectIn && lockBits != 2'b00 |=> !wrGrant && wrDeny)
    else $error("write passed while protected and locked");

  a_open_write_granted: assert property ( // [RULE12]
    ce && wrReq.req && !writeProtectIn |=> wrGrant && !wrDeny)
    else $error("write refused with protection off");

  a_irq_level: assert property (
    ce |=> irq == |($past(status_d) & $past(mask_q)))
    else $error("interrupt does not match masked status");

  // a new cause during the hold throws the count away
  a_hold_restart: assert property ( // [RULE6]
    ce && cause && state_q == ST_HOLD |=> state_q == ST_CAUSE && resetOut)
    else $error("cause during hold did not restart the sequence");

  a_hold_waits: assert property ( // [RULE6] [RULE9]
    ce && state_q == ST_HOLD && !cause && !timerDone |=> state_q == ST_HOLD && resetOut)
    else $error("hold left before the timer expired");

  a_run_reset_low: assert property ( // [RULE5] [RULE8]
    ce && state_q == ST_RUN && !cause |=> !resetOut)
    else $error("reset raised with no cause");

  a_status_sticky: assert property (
    ce && !rdStatus |=> (status_q & $past(status_q)) == $past(status_q))
    else $error("status bit lost without a read");

  a_status_read_clear: assert property (
    ce && rdStatus && event_w == '0 |=> status_q == '0)
    else $error("status read did not clear");

  a_rd_status_data: assert property (
    ce && rdStatus |=> rdData == DATA_W'($past(status_q)))
    else $error("status read returned wrong data");

  a_rd_data_idle: assert property (
    ce && !busReq.re |=> rdData == '0)
    else $error("read data not zero outside a read");

  a_deny_sets_status: assert property ( // [RULE10] [RULE11]
    ce && wrReq.req && wrRefuse |=> status_q[EV_WR_DENY])
    else $error("refused write left no status bit");

  a_write_answer_once: assert property (
    ce && !wrReq.req |=> !wrGrant && !wrDeny)
    else $error("write answer without a request");

  // enable low must freeze every piece of state
  a_freeze_hold: assert property (
    !ce |=> $stable(resetOut) && $stable(state_q) && $stable(status_q))
    else $error("state moved while enable was low");

endmodule

/* testbench/srwg_host_model.sv */
// host-side model: supply and manual reset drivers, reset pulse timing
`timescale 1ns/1ps

module srwg_host_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // requests from the bench
  input  wire logic        wantLow,
  input  wire logic        wantManual,
  // device pins
  input  wire logic        resetOut,
  output logic             supplyLowIn = 1'b0,
  output logic             manualResetIn = 1'b0,
  // cycles of reset seen once every cause has gone
  output logic [15:0]      holdCount = 16'h0000
);
  ////////////////////////////////////////////////////////////
  // the pins move one edge after a request, as a board would
  always @(posedge clk) begin
    supplyLowIn   <= wantLow;
    manualResetIn <= wantManual;
    if (rst || supplyLowIn || manualResetIn) begin
      holdCount <= 16'h0000;
    end else if (resetOut) begin
      holdCount <= holdCount + 16'h0001;
    end
  end
endmodule

/* testbench/srwg_supervisor_tb.sv */
// self-checking bench for the supervisor reset and write guard
`timescale 1ns/1ps

module srwg_supervisor_tb;
  import srwg_pkg::*;
  localparam int TK = 2;
  localparam int HOLD [4] = '{2, 3, 4, 5};
  logic          clk = 1'b0;
  logic          rst = 1'b1;
  logic          ce = 1'b1;
  logic          wantLow = 1'b0;
  logic          wantManual = 1'b0;
  logic          secondMon = 1'b0;
  logic          thirdMon = 1'b0;
  logic          writeProtect = 1'b0;
  srwg_wr_req_s  wrReq = '0;
  srwg_bus_req_s busReq = '0;
  logic          supplyLow, manualReset, wrGrant, wrDeny, resetOut, fail2, fail3, irq;
  logic [7:0]    rdData;
  logic [15:0]   holdCount;
  int            mismatches = 0;
  int            comparisons = 0;
  int            cycles = 0;

  srwg_supervisor #(.HOLD0(2), .HOLD1(3), .HOLD2(4), .HOLD3(5), .TICKS(TK)) dut (
    .clk(clk), .rst(rst), .ce(ce), .supplyLowIn(supplyLow), .manualResetIn(manualReset),
    .secondMonitorIn(secondMon), .thirdMonitorIn(thirdMon), .writeProtectIn(writeProtect),
    .wrReq(wrReq), .wrGrant(wrGrant), .wrDeny(wrDeny), .busReq(busReq), .rdData(rdData),
    .resetOut(resetOut), .secondMonitorFailOut(fail2), .thirdMonitorFailOut(fail3), .irq(irq));

  srwg_host_model host (
    .clk(clk), .rst(rst), .wantLow(wantLow), .wantManual(wantManual), .resetOut(resetOut),
    .supplyLowIn(supplyLow), .manualResetIn(manualReset), .holdCount(holdCount));

  ////////////////////////////////////////////////////////////
  initial begin
    forever #12.5 clk = ~clk;
  end

  // whole run is well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      report_and_stop();
    end
  end

  ////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // prescaler restarts with the timer; two flop stages add two cycles
  // window kept narrow so that a wrong select cannot fall inside it
  task automatic in_range(input logic [15:0] got, input int sel);
    int lo;
    lo = HOLD[sel] * TK;
    comparisons++;
    if ($isunknown(got) || got < lo + 1 || got > lo + TK) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, 16'(lo));
    end
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    busReq <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    busReq.we <= 1'b0;
  endtask

  task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    busReq <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    busReq.re <= 1'b0;
    #1;
    d = rdData;
  endtask

  task automatic wait_release();
    repeat (200) begin
      @(posedge clk);
      #1;
      if (resetOut === 1'b0) break;
    end
  endtask

  task automatic mon(input logic s, input logic t);
    @(posedge clk);
    secondMon <= s;
    thirdMon <= t;
    @(posedge clk);
    #1;
    chk({fail2, fail3}, {s, t});
  endtask

  task automatic guard(input logic wp, input logic [1:0] lock, input logic nv);
    logic deny;
    deny = wp & (nv | (lock != 2'b00));
    reg_wr(OFF_CTRL, {4'h0, lock, 2'b00});
    writeProtect <= wp;
    @(posedge clk);
    wrReq <= '{1'b1, nv};
    @(posedge clk);
    wrReq <= '0;
    #1;
    chk({wrGrant, wrDeny}, {~deny, deny});
  endtask

  ////////////////////////////////////////////////////////////
  // monitor moves during the power-up hold must show at once
  task automatic t_powerup();
    mon(1'b1, 1'b0);
    chk(resetOut, 1'b1);
    mon(1'b0, 1'b0);
    wait_release();
    in_range(holdCount, 0);
  endtask

  task automatic t_regs();
    logic [7:0] d;
    reg_rd(OFF_CTRL, d);
    chk(d, 8'h00);
    reg_rd(OFF_MASK, d);
    chk(d, 8'h00);
    reg_rd(OFF_STATE, d);
    chk(d, 8'h40);
    reg_rd(4'h2, d);
    chk(d, 8'h00);
    reg_wr(OFF_CTRL, 8'h0F);
    reg_rd(OFF_CTRL, d);
    chk(d, 8'h0F);
    reg_wr(OFF_CTRL, 8'h00);
  endtask

  task automatic t_cause(input logic viaSupply, input int sel);
    reg_wr(OFF_CTRL, 8'(sel));
    wantLow <= viaSupply;
    wantManual <= ~viaSupply;
    repeat (3) @(posedge clk);
    #1;
    chk(resetOut, 1'b1);
    @(posedge clk);
    wantLow <= 1'b0;
    wantManual <= 1'b0;
    wait_release();
    in_range(holdCount, sel);
  endtask

  task automatic t_monitors();
    logic [7:0] d;
    reg_rd(OFF_STATUS, d);
    reg_wr(OFF_MASK, 8'h0C);
    mon(1'b1, 1'b0);
    mon(1'b1, 1'b1);
    repeat (3) @(posedge clk);
    #1;
    chk(irq, 1'b1);
    reg_rd(OFF_STATUS, d);
    chk(d, 8'h0C);
    mon(1'b0, 1'b0);
    reg_rd(OFF_STATUS, d);
    reg_wr(OFF_MASK, 8'h10);
  endtask

  // a refusal with its mask set raises irq, one status read drops it
  task automatic t_irq();
    logic [7:0] d;
    reg_rd(OFF_STATUS, d);
    guard(1'b1, 2'b00, 1'b1);
    repeat (3) @(posedge clk);
    #1;
    chk(irq, 1'b1);
    reg_rd(OFF_STATUS, d);
    chk(d, 8'h10);
    repeat (2) @(posedge clk);
    #1;
    chk(irq, 1'b0);
    reg_rd(OFF_STATUS, d);
    chk(d, 8'h00);
  endtask

  // enable low freezes the block; a cause raised meanwhile acts once it is back
  task automatic t_freeze();
    logic [7:0] d;
    reg_rd(OFF_STATUS, d);
    @(posedge clk);
    ce <= 1'b0;
    secondMon <= 1'b1;
    wantManual <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk({resetOut, fail2}, 2'b00);
    @(posedge clk);
    ce <= 1'b1;
    wantManual <= 1'b0;
    @(posedge clk);
    #1;
    chk({resetOut, fail2}, 2'b11);
    wait_release();
    in_range(holdCount, 0);
    reg_rd(OFF_STATUS, d);
    chk(d, 8'h07);
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_powerup();
    t_regs();
    for (int s = 0; s < 4; s++) begin
      t_cause(1'b0, s);
    end
    t_cause(1'b1, 1);
    t_monitors();
    for (int w = 0; w < 2; w++) begin
      for (int l = 0; l < 4; l++) begin
        guard(w[0], l[1:0], 1'b0);
        guard(w[0], l[1:0], 1'b1);
      end
    end
    t_irq();
    t_freeze();
    report_and_stop();
  end
endmodule
